/* File: inc/tsoc_act_if.sv */
`timescale 1ns/1ns
`default_nettype none

// carries one channel's match events and action selects to the pin resolver
interface tsoc_act_if;
    logic       hit_a;
    logic       hit_b;
    logic [1:0] a_sel;
    logic [1:0] b_sel;
    logic       cur;
    logic       nxt;

    modport ctrl (output hit_a, output hit_b, output a_sel, output b_sel, output cur,
                  input nxt);
    modport act  (input hit_a, input hit_b, input a_sel, input b_sel, input cur,
                  output nxt);
endinterface : tsoc_act_if

`default_nettype wire

/* File: inc/tsoc_pkg.sv */
package tsoc_pkg;

    // channel count and counter width
    localparam int NUM_CH = 4;
    localparam int CNT_W  = 8;

    // status/control register field positions
    localparam int BIT_FLAG_B   = 7;
    localparam int BIT_FLAG_A   = 6;
    localparam int BIT_WRAP     = 5;
    localparam int BIT_MODE     = 4;  // trigger source select / capture select / spare
    localparam int BIT_B_SEL_HI = 3;
    localparam int BIT_B_SEL_LO = 2;
    localparam int BIT_A_SEL_HI = 1;
    localparam int BIT_A_SEL_LO = 0;

    // reset and standby values of the four status/control registers
    localparam logic [7:0] CSR_RST_CH0 = 8'h00;
    localparam logic [7:0] CSR_RST_CH1 = 8'h00;
    localparam logic [7:0] CSR_RST_CH2 = 8'h10;
    localparam logic [7:0] CSR_RST_CH3 = 8'h00;

    // counter value from which the counter wraps to zero
    localparam logic [7:0] CNT_MAX = 8'hFF;

    // pin action codes; the numeric order is also the priority order
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // capture edge codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // edge of the external conversion trigger pin that starts a conversion
    localparam logic [1:0] EXT_TRIG_EDGE = 2'h1;

endpackage : tsoc_pkg

/* File: rtl/tsoc_edge_detect.sv */
`timescale 1ns/1ns
`default_nettype none

module tsoc_edge_detect (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    output logic            edge_hit
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tsoc_edge_state_t;

    tsoc_edge_state_t st_r;
    tsoc_edge_state_t st_nxt;

    // two-stage synchroniser then one history stage; s1 feeds s2 only
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // edge decode; the unused code detects nothing
    always_comb begin
        case (edge_sel)
            tsoc_pkg::EDGE_RISE: edge_hit = st_r.s2 & ~st_r.s3;
            tsoc_pkg::EDGE_FALL: edge_hit = ~st_r.s2 & st_r.s3;
            tsoc_pkg::EDGE_BOTH: edge_hit = st_r.s2 ^ st_r.s3;
            default:             edge_hit = 1'b0;
        endcase
    end
endmodule : tsoc_edge_detect

`default_nettype wire

/* File: rtl/tsoc_pin_action.sv */
`timescale 1ns/1ns
`default_nettype none

module tsoc_pin_action (
    tsoc_act_if.act port_a
);
    logic [1:0] code_a;
    logic [1:0] code_b;
    logic [1:0] code_win;

    // codes are ordered toggle > high > low, so the larger one wins
    always_comb begin
        code_a   = port_a.hit_a ? port_a.a_sel : tsoc_pkg::ACT_NONE;
        code_b   = port_a.hit_b ? port_a.b_sel : tsoc_pkg::ACT_NONE;
        code_win = (code_a > code_b) ? code_a : code_b;
        case (code_win)
            tsoc_pkg::ACT_LOW:    port_a.nxt = 1'b0;
            tsoc_pkg::ACT_HIGH:   port_a.nxt = 1'b1;
            tsoc_pkg::ACT_TOGGLE: port_a.nxt = ~port_a.cur;
            default:              port_a.nxt = port_a.cur;
        endcase
    end
endmodule : tsoc_pin_action

`default_nettype wire

/* File: rtl/tsoc_status_output_ctrl.sv */
// Contract
// - writing one to bits 7 to 5 has no effect; zero may only clear
// - a flag clears only on a zero write after a read that saw it set
// - match_b_flag sets on counter equal const_b, or on a capture
// - odd channel in capture mode blocks even channel match_b_flag on compare
// - match_a_flag sets when counter equals const_a
// - wrap_flag sets when the counter rolls over from its maximum to zero
// - reset and standby load channel 2 with 0x10, the others with zero
// - conversion start gated by master enable, then trigger pin or ch0 match A
// - bit 4 holds the value last written and reads it back
// - bit 4 of odd channels selects compare or capture use of const_b
// - in capture mode the even channel's match B drives no pin, no irq
// - in capture mode the odd pin is input only; capture sets match_b_flag
// - b_action_sel in compare mode: none, low, high, toggle
// - b_action_sel in capture mode: rising, falling, both, none
// - a_action_sel: none, low, high, toggle on match A
// - simultaneous A and B matches apply the higher-priority pin action
// - all four action bits zero disables the channel's timer output
// - interrupt requests only while flag set and its enable is one
// - matches register on the counting pulse that leaves the matched value
`timescale 1ns/1ns
`default_nettype none

module tsoc_status_output_ctrl (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            standby,
    input  wire logic [1:0]      reg_sel,
    input  wire logic            reg_rd,
    input  wire logic            reg_wr,
    input  wire logic [7:0]      reg_wdata,
    output logic      [7:0]      reg_rdata,
    input  wire logic [3:0][7:0] tick_counter,
    input  wire logic [3:0][7:0] const_a,
    input  wire logic [3:0][7:0] const_b,
    input  wire logic [3:0]      count_tick,
    input  wire logic [3:0]      match_a_irq_enable,
    input  wire logic [3:0]      match_b_irq_enable,
    input  wire logic [3:0]      wrap_irq_enable,
    input  wire logic            conv_trigger_master,
    input  wire logic            ext_conv_trigger_pin,
    input  wire logic [1:0]      odd_wave_capture_pin_in,
    output logic      [1:0]      odd_wave_capture_pin_out,
    output logic      [1:0]      odd_wave_capture_pin_oe,
    output logic      [1:0]      even_wave_pin,
    output logic      [1:0]      even_wave_oe,
    output logic      [3:0]      match_a_irq,
    output logic      [3:0]      match_b_irq,
    output logic      [3:0]      wrap_irq,
    output logic      [1:0]      capture_load,
    output logic                 conv_start_req
);
    typedef struct packed {
        logic [3:0][7:0] csr;
        logic [3:0][2:0] armed;     // flags seen at one by reads since the last write
        logic [3:0]      pin;
        logic [3:0]      oe;
        logic [3:0]      irq_a;
        logic [3:0]      irq_b;
        logic [3:0]      irq_w;
        logic [1:0]      cap_load;
        logic            conv_start;
        logic [7:0]      rdata;
    } tsoc_state_t;

    tsoc_state_t st_r;
    tsoc_state_t st_nxt;

    // a match counts only on the pulse that moves the counter off the value
    function automatic logic cnt_hit(input logic tick, input logic [7:0] cnt,
                                     input logic [7:0] ref_val);
        cnt_hit = tick && (cnt == ref_val);
    endfunction : cnt_hit

    // reset and standby image
    function automatic tsoc_state_t init_state();
        tsoc_state_t v;
        v        = '0;
        v.csr[0] = tsoc_pkg::CSR_RST_CH0;
        v.csr[1] = tsoc_pkg::CSR_RST_CH1;
        v.csr[2] = tsoc_pkg::CSR_RST_CH2;
        v.csr[3] = tsoc_pkg::CSR_RST_CH3;
        init_state = v;
    endfunction : init_state

    logic [1:0] cap_edge;
    logic       ext_edge;
    logic [3:0] hit_a;
    logic [3:0] hit_b;
    logic [3:0] hit_w;
    logic [3:0] cap_ev;
    logic [3:0] pin_nxt;
    logic [3:0] cap_mode;

    // capture pins pass the synchroniser; edge chosen by the odd channel
    tsoc_edge_detect u_cap_edge_ch1 (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pin_in   (odd_wave_capture_pin_in[0]),
        .edge_sel (st_r.csr[1][tsoc_pkg::BIT_B_SEL_HI:tsoc_pkg::BIT_B_SEL_LO]),
        .edge_hit (cap_edge[0])
    );

    tsoc_edge_detect u_cap_edge_ch3 (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pin_in   (odd_wave_capture_pin_in[1]),
        .edge_sel (st_r.csr[3][tsoc_pkg::BIT_B_SEL_HI:tsoc_pkg::BIT_B_SEL_LO]),
        .edge_hit (cap_edge[1])
    );

    // external conversion trigger, also synchronised before use
    tsoc_edge_detect u_ext_trig (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pin_in   (ext_conv_trigger_pin),
        .edge_sel (tsoc_pkg::EXT_TRIG_EDGE),
        .edge_hit (ext_edge)
    );

    // per-channel event decode
    always_comb begin
        for (int c = 0; c < tsoc_pkg::NUM_CH; c++) begin
            // bit 4 of the odd channel of the pair selects capture use
            cap_mode[c] = st_r.csr[c | 1][tsoc_pkg::BIT_MODE];
            hit_a[c]    = cnt_hit(count_tick[c], tick_counter[c], const_a[c]);
            hit_w[c]    = cnt_hit(count_tick[c], tick_counter[c], tsoc_pkg::CNT_MAX);
            // compare B is dropped in capture mode for both channels of a pair
            hit_b[c]    = cnt_hit(count_tick[c], tick_counter[c], const_b[c])
                          && !cap_mode[c];
            cap_ev[c]   = ((c % 2) == 1) && cap_mode[c] && cap_edge[c / 2];
        end
    end

    // one pin resolver per channel, joined through the action interface
    for (genvar g = 0; g < tsoc_pkg::NUM_CH; g++) begin : g_pin
        tsoc_act_if act_if ();

        assign act_if.hit_a = hit_a[g];
        assign act_if.hit_b = hit_b[g];
        assign act_if.a_sel = st_r.csr[g][tsoc_pkg::BIT_A_SEL_HI:tsoc_pkg::BIT_A_SEL_LO];
        assign act_if.b_sel = st_r.csr[g][tsoc_pkg::BIT_B_SEL_HI:tsoc_pkg::BIT_B_SEL_LO];
        assign act_if.cur   = st_r.pin[g];
        assign pin_nxt[g]   = act_if.nxt;

        tsoc_pin_action u_act (
            .port_a (act_if)
        );
    end

    // register access, flag setting, pins and request outputs
    always_comb begin
        st_nxt          = st_r;
        st_nxt.cap_load = '0;
        for (int c = 0; c < tsoc_pkg::NUM_CH; c++) begin
            if (reg_wr && (reg_sel == 2'(c))) begin
                // bit 4 and the action selects store as written
                st_nxt.csr[c][4:0] = reg_wdata[4:0];
                for (int f = 0; f < 3; f++) begin
                    // a one is ignored; a zero clears only an armed flag
                    if (!reg_wdata[tsoc_pkg::BIT_WRAP + f] && st_r.armed[c][f]) begin
                        st_nxt.csr[c][tsoc_pkg::BIT_WRAP + f] = 1'b0;
                    end
                end
                st_nxt.armed[c] = '0;
            end else if (reg_rd && (reg_sel == 2'(c))) begin
                // remember which flags software has seen at one
                st_nxt.armed[c] = st_r.armed[c]
                                  | st_r.csr[c][tsoc_pkg::BIT_FLAG_B:tsoc_pkg::BIT_WRAP];
                st_nxt.rdata    = st_r.csr[c];
            end
            // setting is applied after clearing so a coincident event survives
            if (hit_b[c] || cap_ev[c]) begin
                st_nxt.csr[c][tsoc_pkg::BIT_FLAG_B] = 1'b1;
            end
            if (hit_a[c]) begin
                st_nxt.csr[c][tsoc_pkg::BIT_FLAG_A] = 1'b1;
            end
            if (hit_w[c]) begin
                st_nxt.csr[c][tsoc_pkg::BIT_WRAP] = 1'b1;
            end
            // interrupt levels follow the flag gated by its enable
            st_nxt.irq_a[c] = st_nxt.csr[c][tsoc_pkg::BIT_FLAG_A]
                              && match_a_irq_enable[c];
            st_nxt.irq_b[c] = st_nxt.csr[c][tsoc_pkg::BIT_FLAG_B]
                              && match_b_irq_enable[c];
            st_nxt.irq_w[c] = st_nxt.csr[c][tsoc_pkg::BIT_WRAP] && wrap_irq_enable[c];
            st_nxt.pin[c]   = pin_nxt[c];
            // output enabled when any action bit is set and not a capture input
            st_nxt.oe[c]    = (|st_nxt.csr[c][3:0])
                              && !(((c % 2) == 1)
                              && st_nxt.csr[c][tsoc_pkg::BIT_MODE]);
        end
        // capture strobes tell the counter logic to copy into const_b
        st_nxt.cap_load[0] = cap_ev[1];
        st_nxt.cap_load[1] = cap_ev[3];
        // conversion start: master gate first, then trigger source choice
        st_nxt.conv_start  = conv_trigger_master
                             && (st_r.csr[0][tsoc_pkg::BIT_MODE] ? hit_a[0] : ext_edge);
        if (standby) begin
            st_nxt = init_state();
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= init_state();
        end else begin
            st_r <= st_nxt;
        end
    end

    // all outputs straight from the state register
    assign reg_rdata                = st_r.rdata;
    assign even_wave_pin            = {st_r.pin[2], st_r.pin[0]};
    assign even_wave_oe             = {st_r.oe[2], st_r.oe[0]};
    assign odd_wave_capture_pin_out = {st_r.pin[3], st_r.pin[1]};
    assign odd_wave_capture_pin_oe  = {st_r.oe[3], st_r.oe[1]};
    assign match_a_irq              = st_r.irq_a;
    assign match_b_irq              = st_r.irq_b;
    assign wrap_irq                 = st_r.irq_w;
    assign capture_load             = st_r.cap_load;
    assign conv_start_req           = st_r.conv_start;
endmodule : tsoc_status_output_ctrl

`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic            standby = 1'b0;
    logic [1:0]      reg_sel = 2'h0;
    logic            reg_rd = 1'b0;
    logic            reg_wr = 1'b0;
    logic [7:0]      reg_wdata = 8'h00;
    logic [7:0]      reg_rdata;
    logic [3:0][7:0] tick_counter;
    logic [3:0][7:0] const_a = 32'h4040_4040;
    logic [3:0][7:0] const_b;
    logic [3:0]      count_tick, step = 4'h0, ld = 4'h0;
    logic [3:0]      match_a_irq_enable = 4'h0, match_b_irq_enable = 4'h0;
    logic [3:0]      wrap_irq_enable = 4'h0, match_a_irq, match_b_irq, wrap_irq;
    logic [7:0]      ld_val = 8'h00;
    logic            conv_trigger_master = 1'b0, ext_conv_trigger_pin = 1'b1;
    logic [1:0]      odd_wave_capture_pin_in = 2'h0, odd_wave_capture_pin_out;
    logic [1:0]      odd_wave_capture_pin_oe, even_wave_pin, even_wave_oe, capture_load;
    logic            conv_start_req;
    int              num_errors = 0, check_count = 0, conv_cnt = 0;
    // {csr0 written, pin expected, enable expected}; a and b match together
    logic [9:0]      rows [7] = '{10'h005, 10'h027, 10'h011, 10'h00B, 10'h035, 10'h01F,
                                  10'h002};

    tsoc_status_output_ctrl uut (.*);
    tsoc_count_model        u_cnt (.*);

    // free-running clock and a tally of conversion start pulses
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (conv_start_req === 1'b1) conv_cnt++;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(posedge ref_clk);
        reg_sel <= s;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [1:0] s, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_sel <= s;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdc

    // preload a counter, give it one counting pulse, let results land
    task automatic tk(input int ch, input logic [7:0] v);
        @(posedge ref_clk);
        ld <= 4'h1 << ch;
        ld_val <= v;
        @(posedge ref_clk);
        ld <= 4'h0;
        step <= 4'h1 << ch;
        @(posedge ref_clk);
        step <= 4'h0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : tk

    // drive a pin at an edge, then allow the synchronisers to settle
    task automatic pin(input logic ext, input logic [1:0] odd);
        @(posedge ref_clk);
        ext_conv_trigger_pin <= ext;
        odd_wave_capture_pin_in <= odd;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : pin

    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    // bounded run: the sequence needs well under a thousand cycles
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(2'h0, 8'h00);
        rdc(2'h1, 8'h00);
        rdc(2'h2, 8'h10);
        rdc(2'h3, 8'h00);
        @(posedge ref_clk);
        match_a_irq_enable <= 4'hF;
        match_b_irq_enable <= 4'hF;
        wrap_irq_enable <= 4'hF;
        foreach (rows[i]) begin
            wr(2'h0, rows[i][9:2]);
            tk(0, 8'h40);
            chk(even_wave_pin[0], rows[i][1]);
            chk(even_wave_oe[0], rows[i][0]);
        end
        wr(2'h0, 8'h00);
        rdc(2'h0, 8'hC0);
        wr(2'h0, 8'hFF);
        rdc(2'h0, 8'hDF);
        wr(2'h0, 8'h10);
        rdc(2'h0, 8'h10);
        @(posedge ref_clk);
        conv_trigger_master <= 1'b1;
        tk(0, 8'h40);
        chk(conv_cnt[7:0], 8'h01);
        pin(1'b0, 2'h0);
        pin(1'b1, 2'h0);
        chk(conv_cnt[7:0], 8'h01);
        wr(2'h0, 8'h00);
        pin(1'b0, 2'h0);
        pin(1'b1, 2'h0);
        chk(conv_cnt[7:0], 8'h02);
        tk(0, 8'h40);
        chk(conv_cnt[7:0], 8'h02);
        rdc(2'h0, 8'hC0);
        wr(2'h0, 8'h00);
        rdc(2'h0, 8'h00);
        tk(1, 8'hFF);
        chk(wrap_irq[1], 1'b1);
        rdc(2'h1, 8'h20);
        wr(2'h1, 8'h10);
        tk(0, 8'h40);
        chk(match_b_irq[0], 1'b0);
        rdc(2'h0, 8'h40);
        tk(1, 8'h25);
        pin(1'b1, 2'h1);
        chk(const_b[1], 8'h26);
        chk(odd_wave_capture_pin_oe[0], 1'b0);
        rdc(2'h1, 8'h90);
        wr(2'h1, 8'h14);
        tk(1, 8'h50);
        pin(1'b1, 2'h0);
        chk(const_b[1], 8'h51);
        rdc(2'h1, 8'h94);
        wr(2'h1, 8'h1C);
        tk(1, 8'h60);
        pin(1'b1, 2'h1);
        chk(const_b[1], 8'h51);
        wr(2'h2, 8'h00);
        rdc(2'h2, 8'h00);
        @(posedge ref_clk);
        standby <= 1'b1;
        @(posedge ref_clk);
        standby <= 1'b0;
        rdc(2'h2, 8'h10);
        rdc(2'h1, 8'h00);
        // odd channel in compare mode drives its own pin
        wr(2'h1, 8'h03);
        tk(1, 8'h40);
        chk(odd_wave_capture_pin_out[0], 1'b1);
        chk(odd_wave_capture_pin_oe[0], 1'b1);
        // arm both flags, then a clearing write lands on the edge of a new match
        tk(0, 8'h40);
        rdc(2'h0, 8'hC0);
        @(posedge ref_clk);
        reg_sel <= 2'h0;
        ld <= 4'h1;
        ld_val <= 8'h40;
        @(posedge ref_clk);
        ld <= 4'h0;
        step <= 4'h1;
        reg_wr <= 1'b1;
        reg_wdata <= 8'h00;
        @(posedge ref_clk);
        step <= 4'h0;
        reg_wr <= 1'b0;
        rdc(2'h0, 8'hC0);
        // an equal count with no counting pulse must not set a flag
        wr(2'h0, 8'h00);
        @(posedge ref_clk);
        ld <= 4'h1;
        @(posedge ref_clk);
        ld <= 4'h0;
        repeat (3) @(posedge ref_clk);
        rdc(2'h0, 8'h00);
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire

/* File: testbench/tsoc_count_model.sv */
`timescale 1ns/1ns
`default_nettype none

module tsoc_count_model (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic [3:0]      step,
    input  wire logic [3:0]      ld,
    input  wire logic [7:0]      ld_val,
    input  wire logic [1:0]      capture_load,
    output logic      [3:0][7:0] tick_counter,
    output logic      [3:0]      count_tick,
    output logic      [3:0][7:0] const_b
);
    // the counter value shown is the one being left on a counting pulse
    assign count_tick = step;

    // counters and compare-b registers; capture copies the live count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_counter <= '0;
            const_b      <= 32'h4040_4040;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ld[i]) begin
                    tick_counter[i] <= ld_val;
                end else if (step[i]) begin
                    tick_counter[i] <= tick_counter[i] + 8'h01;
                end
            end
            if (capture_load[0]) const_b[1] <= tick_counter[1];
            if (capture_load[1]) const_b[3] <= tick_counter[3];
        end
    end
endmodule : tsoc_count_model

`default_nettype wire

/* File: testbench/tsoc_properties.sv */
`timescale 1ns/1ns
`default_nettype none

module tsoc_properties (
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire logic            standby,
    input wire logic            reg_rd,
    input wire logic [7:0]      reg_rdata,
    input wire logic [3:0][7:0] tick_counter,
    input wire logic [3:0][7:0] const_a,
    input wire logic [3:0]      count_tick,
    input wire logic [3:0]      match_a_irq_enable,
    input wire logic [3:0]      match_b_irq_enable,
    input wire logic [3:0]      wrap_irq_enable,
    input wire logic            conv_trigger_master,
    input wire logic [3:0]      match_a_irq,
    input wire logic [3:0]      match_b_irq,
    input wire logic [3:0]      wrap_irq,
    input wire logic [1:0]      capture_load,
    input wire logic            conv_start_req
);
    // one clock domain, so one default clock and reset for all checks
    default clocking cb_main @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_irq_a_gate: assert property (
        match_a_irq_enable == 4'h0 |=> match_a_irq == 4'h0) else $error("irq a without enable");
    a_irq_b_gate: assert property (
        match_b_irq_enable == 4'h0 |=> match_b_irq == 4'h0) else $error("irq b without enable");
    a_wrap_irq_gate: assert property (
        wrap_irq_enable == 4'h0 |=> wrap_irq == 4'h0) else $error("wrap irq without enable");
    a_conv_master_off: assert property (
        !conv_trigger_master |=> !conv_start_req) else $error("conversion start while masked");
    a_conv_one_pulse: assert property (
        conv_start_req |=> !conv_start_req) else $error("conversion start longer than a pulse");
    a_match_a_sets: assert property (
        count_tick[0] && tick_counter[0] == const_a[0] && !standby
        ##1 match_a_irq_enable[0] && !standby |=> match_a_irq[0]) else $error("match a lost");
    a_wrap_sets: assert property (
        count_tick[1] && tick_counter[1] == 8'hFF && !standby
        ##1 wrap_irq_enable[1] && !standby |=> wrap_irq[1]) else $error("wrap lost");
    a_capture_flag: assert property (
        capture_load[0] && !standby ##1 match_b_irq_enable[1] && !standby
        |=> match_b_irq[1]) else $error("capture left no flag");
    a_rdata_holds: assert property (
        !reg_rd && !standby |=> $stable(reg_rdata)) else $error("read data moved");

    // main scenarios reached
    c_conv: cover property (conv_start_req);
    c_capture: cover property (capture_load[0]);
    c_wrap: cover property (wrap_irq[1]);
endmodule : tsoc_properties

bind tsoc_status_output_ctrl tsoc_properties u_props (.*);

`default_nettype wire
